// >>> src/fieldbus_node_pkg.sv
// Purpose: shared constants and carriers of the fieldbus node setup block
// Assumes: 250 MHz system clock, 32-bit AHB-Lite register access
// Notes: all offsets are byte addresses of word registers
package fieldbus_node_pkg;

    // -------------------------------------------------------------------
    // clock and timing
    // -------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int CLK_KHZ = 1000000 / CLK_PERIOD_NS;
    localparam int FLICKER_NS = 50000000;
    localparam int FLICKER_CYC = FLICKER_NS / CLK_PERIOD_NS;
    localparam int DETECT_EDGES = 64;

    // -------------------------------------------------------------------
    // register map
    // -------------------------------------------------------------------
    localparam logic [4:0] OFS_NET_CFG = 5'h00;
    localparam logic [4:0] OFS_FAULT_CFG = 5'h04;
    localparam logic [4:0] OFS_DRIVE_CFG = 5'h08;
    localparam logic [4:0] OFS_STATUS = 5'h0c;
    localparam logic [4:0] OFS_EVENT = 5'h10;

    // -------------------------------------------------------------------
    // codes and reset values
    // -------------------------------------------------------------------
    localparam logic [3:0] RATE_AUTO = 4'h0;
    localparam logic [3:0] RATE_MAX_CODE = 4'h8;
    localparam logic [3:0] RATE_CODE_RST = 4'h6;
    localparam logic [6:0] NODE_ID_MAX = 7'h7e;
    localparam logic [6:0] NODE_ID_RST = 7'h00;
    localparam logic [1:0] STOP_RAMP = 2'h0;
    localparam logic [1:0] STOP_COAST = 2'h1;
    localparam logic [1:0] STOP_FAST = 2'h2;
    localparam logic [1:0] STOP_ALARM_ONLY = 2'h3;
    localparam logic [1:0] COMM_RESP_RST = 2'h1;
    localparam logic EXT_DETECT_RST = 1'b0;
    localparam logic [1:0] EXT_STOP_RST = 2'h1;
    localparam logic MULTISTEP_RST = 1'b1;
    localparam logic COMM_RESET_RST = 1'b0;
    localparam logic [2:0] FREQ_SRC_RST = 3'h1;
    localparam logic [2:0] FREQ_SRC_MAX = 3'h4;
    localparam logic [1:0] RUN_SRC_RST = 2'h1;
    localparam logic [1:0] SRC_OPTION_CARD = 2'h3;
    localparam logic [1:0] DISPLAY_RST = 2'h0;
    localparam logic [5:0] POLES_RST = 6'h04;
    localparam logic [5:0] POLES_MIN = 6'h02;
    localparam logic [5:0] POLES_MAX = 6'h30;

    // nominal rates in kbps, index = bit rate code
    localparam int RATE_KBPS [0:8] = '{0, 10, 20, 50, 125, 250, 500, 800,
                                       1000};

    typedef enum logic [4:0] {
        ST_LATCH = 5'b00001,
        ST_DETECT = 5'b00010,
        ST_BOOT = 5'b00100,
        ST_PREOP = 5'b01000,
        ST_HALT = 5'b10000
    } node_state_t;

    typedef struct packed {
        logic tx_inhibit;
        logic bootup_req;
        logic [6:0] node_id;
        logic [3:0] rate_code;
        logic [15:0] bit_period;
        logic preop;
    } net_ctl_t;

    typedef struct packed {
        logic run_from_network;
        logic ref_from_network;
        logic [1:0] run_src;
        logic [2:0] freq_src;
        logic [1:0] display_unit;
        logic [5:0] pole_count;
        logic multistep_allow;
        logic stop_req;
        logic [1:0] stop_method;
        logic alarm;
        logic addr_err_display;
        logic cfg_err;
    } drive_ctl_t;

endpackage

// >>> src/fieldbus_node_bitrate_setup.sv
// Purpose: start-up, bit rate and drive reaction logic of a fieldbus node
// Assumes: nv settings valid at reset release, drive inputs on i_clk
// Notes: the can controller proper sits outside and obeys o_net
`timescale 1ns/1ps

module fieldbus_node_bitrate_setup #(
    parameter logic [3:0] BIT_RATE_DEFAULT = fieldbus_node_pkg::RATE_CODE_RST,
    parameter int FLICKER_CYCLES = fieldbus_node_pkg::FLICKER_CYC,
    parameter int DETECT_EDGE_COUNT = fieldbus_node_pkg::DETECT_EDGES
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    input wire logic [3:0] i_nv_bit_rate_code,
    input wire logic [6:0] i_nv_node_id,
    input wire logic i_can_rx,
    input wire logic i_comm_error,
    input wire logic i_ext_fault,
    input wire logic i_drive_running,
    input wire logic i_drive_init,
    output fieldbus_node_pkg::net_ctl_t o_net,
    output fieldbus_node_pkg::drive_ctl_t o_drive,
    output logic o_run_led,
    output logic o_err_led
);
    import fieldbus_node_pkg::*;

    // -------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------
    typedef struct packed {
        node_state_t st;
        logic [3:0] bit_rate_code;
        logic [6:0] node_identifier_setting;
        logic [1:0] comm_error_response_sel;
        logic ext_fault_detect_condition;
        logic [1:0] ext_fault_stop_method;
        logic multistep_reference_allow;
        logic comm_param_reset_on_init;
        logic [2:0] freq_reference_source_sel;
        logic [1:0] run_command_source_sel;
        logic [1:0] speed_display_unit_sel;
        logic [5:0] motor_pole_count;
        logic [3:0] act_rate;
        logic [6:0] act_id;
        logic addr_err, cfg_err;
        logic rx_s1, rx_s2, rx_prev;
        logic [15:0] ivl;
        logic [15:0] min_ivl;
        logic [7:0] edges;
        logic [23:0] led_cnt;
        logic led_ph, run_led, err_led;
        logic comm_lat, ext_lat, alarm;
        logic stop_req;
        logic [1:0] stop_method;
        logic boot_req;
        logic [15:0] bit_period;
        logic ph_wr, ph_rd, rd_done;
        logic [4:0] ph_addr;
        logic [31:0] hrdata;
    } state_t;
    state_t s_q, s_d;

    // -------------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------------
    function automatic logic [15:0] rate_period(input logic [3:0] code);
        int p;
        p = 0;
        if (code != RATE_AUTO && code <= RATE_MAX_CODE) begin
            p = CLK_KHZ / RATE_KBPS[code];
        end
        return p[15:0];
    endfunction
    // nearest nominal bit time within one eighth; 0 means no match
    function automatic logic [3:0] classify(input logic [15:0] ivl);
        logic [3:0] code;
        logic [15:0] p;
        code = RATE_AUTO;
        for (int i = 1; i <= 8; i++) begin
            p = rate_period(i[3:0]);
            if (ivl >= p - (p >> 3) && ivl <= p + (p >> 3)) begin
                code = i[3:0];
            end
        end
        return code;
    endfunction
    function automatic logic [31:0] read_mux(input state_t s);
        logic [31:0] r;
        r = 32'h0;
        case (s.ph_addr)
            OFS_NET_CFG: begin
                r[3:0] = s.bit_rate_code;
                r[14:8] = s.node_identifier_setting;
            end
            OFS_FAULT_CFG: begin
                r[1:0] = s.comm_error_response_sel;
                r[4] = s.ext_fault_detect_condition;
                r[9:8] = s.ext_fault_stop_method;
                r[12] = s.multistep_reference_allow;
                r[16] = s.comm_param_reset_on_init;
            end
            OFS_DRIVE_CFG: begin
                r[2:0] = s.freq_reference_source_sel;
                r[9:8] = s.run_command_source_sel;
                r[17:16] = s.speed_display_unit_sel;
                r[29:24] = s.motor_pole_count;
            end
            OFS_STATUS: begin
                r[4:0] = s.st;
                r[11:8] = s.act_rate;
                r[22:16] = s.act_id;
                r[24] = s.addr_err;
                r[25] = s.cfg_err;
            end
            OFS_EVENT: begin
                r[0] = s.comm_lat;
                r[1] = s.ext_lat;
                r[2] = s.alarm;
            end
            default: r = 32'h0;
        endcase
        return r;
    endfunction

    // -------------------------------------------------------------------
    // next state
    // -------------------------------------------------------------------
    always_comb begin
        logic accept, rx_edge, comm_ev, ext_ev;
        logic [3:0] found;
        logic [5:0] poles;
        accept = i_hsel && i_htrans[1] && i_hready;
        comm_ev = i_comm_error;
        ext_ev = i_ext_fault
            && (!s_q.ext_fault_detect_condition || i_drive_running);
        s_d = s_q;
        s_d.boot_req = 1'b0;
        s_d.stop_req = 1'b0;
        // pin sync: first stage feeds only the second
        s_d.rx_s1 = i_can_rx;
        s_d.rx_s2 = s_q.rx_s1;
        s_d.rx_prev = s_q.rx_s2;
        rx_edge = s_q.rx_s2 != s_q.rx_prev;
        found = classify(s_q.min_ivl);
        poles = i_hwdata[29:24];
        // register writes land in the data phase, zero wait
        if (s_q.ph_wr) begin
            case (s_q.ph_addr)
                OFS_NET_CFG: begin
                    // stored only; active copy waits for power-up
                    s_d.bit_rate_code = i_hwdata[3:0];
                    if (i_hwdata[14:8] <= NODE_ID_MAX) begin
                        s_d.node_identifier_setting = i_hwdata[14:8];
                    end
                end
                OFS_FAULT_CFG: begin
                    s_d.comm_error_response_sel = i_hwdata[1:0];
                    s_d.ext_fault_detect_condition = i_hwdata[4];
                    s_d.ext_fault_stop_method = i_hwdata[9:8];
                    s_d.multistep_reference_allow = i_hwdata[12];
                    s_d.comm_param_reset_on_init = i_hwdata[16];
                end
                OFS_DRIVE_CFG: begin
                    if (i_hwdata[2:0] <= FREQ_SRC_MAX) begin
                        s_d.freq_reference_source_sel = i_hwdata[2:0];
                    end
                    s_d.run_command_source_sel = i_hwdata[9:8];
                    s_d.speed_display_unit_sel = i_hwdata[17:16];
                    if (poles >= POLES_MIN && poles <= POLES_MAX) begin
                        s_d.motor_pole_count = poles;
                    end
                end
                OFS_EVENT: begin
                    // write one to clear; a same-cycle event sets it again
                    s_d.comm_lat = s_q.comm_lat && !i_hwdata[0];
                    s_d.ext_lat = s_q.ext_lat && !i_hwdata[1];
                    s_d.alarm = s_q.alarm && !i_hwdata[2];
                end
                default: s_d.ph_wr = 1'b0;
            endcase
        end
        // reads take one wait state so hrdata comes from a flop
        if (s_q.ph_rd && !s_q.rd_done) begin
            s_d.hrdata = read_mux(s_q);
            s_d.rd_done = 1'b1;
        end else if (s_q.ph_rd) begin
            s_d.ph_rd = 1'b0;
            s_d.rd_done = 1'b0;
        end
        s_d.ph_wr = 1'b0;
        if (accept) begin
            s_d.ph_wr = i_hwrite;
            s_d.ph_rd = !i_hwrite;
            s_d.rd_done = 1'b0;
            s_d.ph_addr = {i_haddr[4:2], 2'b00};
        end
        // drive init restores communication settings on request
        if (i_drive_init && s_q.comm_param_reset_on_init) begin
            s_d.bit_rate_code = BIT_RATE_DEFAULT;
            s_d.node_identifier_setting = NODE_ID_RST;
            s_d.comm_error_response_sel = COMM_RESP_RST;
            s_d.ext_fault_detect_condition = EXT_DETECT_RST;
            s_d.ext_fault_stop_method = EXT_STOP_RST;
            s_d.multistep_reference_allow = MULTISTEP_RST;
            s_d.comm_param_reset_on_init = COMM_RESET_RST;
        end
        // fault reactions; a new event wins over a clear
        if (comm_ev) begin
            s_d.comm_lat = 1'b1;
            if (s_q.comm_error_response_sel == STOP_ALARM_ONLY) begin
                s_d.alarm = 1'b1;
            end else begin
                s_d.stop_req = 1'b1;
                s_d.stop_method = s_q.comm_error_response_sel;
            end
        end
        if (ext_ev) begin
            s_d.ext_lat = 1'b1;
            if (s_q.ext_fault_stop_method == STOP_ALARM_ONLY) begin
                s_d.alarm = 1'b1; // no stop, drive keeps running
            end else begin
                s_d.stop_req = 1'b1;
                s_d.stop_method = s_q.ext_fault_stop_method;
            end
        end
        // led time base
        if (s_q.led_cnt >= 24'(FLICKER_CYCLES - 1)) begin
            s_d.led_cnt = 24'h0;
            s_d.led_ph = !s_q.led_ph;
        end else begin
            s_d.led_cnt = s_q.led_cnt + 24'h1;
        end
        // edge interval measure, saturating
        if (rx_edge) begin
            s_d.ivl = 16'h0;
            if (s_q.edges != 8'h0 && s_q.ivl < s_q.min_ivl) begin
                s_d.min_ivl = s_q.ivl;
            end
            s_d.edges = s_q.edges + 8'h1;
        end else if (s_q.ivl != 16'hffff) begin
            s_d.ivl = s_q.ivl + 16'h1;
        end
        case (s_q.st)
            ST_LATCH: begin
                // settings caught once, after reset release
                s_d.bit_rate_code = i_nv_bit_rate_code;
                s_d.node_identifier_setting = i_nv_node_id;
                s_d.act_rate = i_nv_bit_rate_code;
                s_d.act_id = i_nv_node_id;
                s_d.edges = 8'h0;
                s_d.min_ivl = 16'hffff;
                if (i_nv_bit_rate_code > RATE_MAX_CODE
                        || i_nv_node_id > NODE_ID_MAX) begin
                    s_d.cfg_err = 1'b1;
                    s_d.st = ST_HALT;
                end else if (i_nv_node_id == 7'h00) begin
                    s_d.addr_err = 1'b1;
                    s_d.st = ST_HALT;
                end else if (i_nv_bit_rate_code == RATE_AUTO) begin
                    s_d.act_rate = RATE_AUTO; // always detect afresh
                    s_d.st = ST_DETECT;
                end else begin
                    s_d.bit_period = rate_period(i_nv_bit_rate_code);
                    s_d.st = ST_BOOT; // fixed rate must match the bus
                end
            end
            ST_DETECT: begin
                // needs traffic from a non-master node at speed
                if (s_q.edges >= 8'(DETECT_EDGE_COUNT)) begin
                    s_d.edges = 8'h0;
                    s_d.min_ivl = 16'hffff;
                    if (found != RATE_AUTO) begin
                        s_d.act_rate = found;
                        s_d.bit_period = rate_period(found);
                        s_d.st = ST_BOOT;
                    end
                end
            end
            ST_BOOT: begin
                s_d.boot_req = 1'b1; // single boot-up request
                s_d.st = ST_PREOP;
            end
            ST_PREOP, ST_HALT: s_d.st = s_q.st;
            default: s_d.st = ST_LATCH;
        endcase
        // indicators
        if (s_q.st == ST_DETECT) begin
            s_d.run_led = s_q.led_ph;
            s_d.err_led = !s_q.led_ph;
        end else if (s_q.addr_err) begin
            s_d.run_led = 1'b0;
            s_d.err_led = s_q.led_ph;
        end else if (s_q.cfg_err) begin
            s_d.run_led = 1'b0;
            s_d.err_led = 1'b1;
        end else begin
            s_d.run_led = s_q.st == ST_PREOP;
            s_d.err_led = 1'b0;
        end
    end

    // -------------------------------------------------------------------
    // registers
    // -------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s_q <= '0;
            s_q.st <= ST_LATCH;
            s_q.bit_rate_code <= BIT_RATE_DEFAULT;
            s_q.node_identifier_setting <= NODE_ID_RST;
            s_q.comm_error_response_sel <= COMM_RESP_RST;
            s_q.ext_fault_detect_condition <= EXT_DETECT_RST;
            s_q.ext_fault_stop_method <= EXT_STOP_RST;
            s_q.multistep_reference_allow <= MULTISTEP_RST;
            s_q.comm_param_reset_on_init <= COMM_RESET_RST;
            s_q.freq_reference_source_sel <= FREQ_SRC_RST;
            s_q.run_command_source_sel <= RUN_SRC_RST;
            s_q.speed_display_unit_sel <= DISPLAY_RST;
            s_q.motor_pole_count <= POLES_RST;
            s_q.rx_s1 <= 1'b1;
            s_q.rx_s2 <= 1'b1;
            s_q.rx_prev <= 1'b1;
            s_q.min_ivl <= 16'hffff;
        end else begin
            s_q <= s_d;
        end
    end

    // -------------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------------
    always_comb begin
        o_hrdata = s_q.hrdata;
        o_hreadyout = !(s_q.ph_rd && !s_q.rd_done);
        o_hresp = 1'b0;
        // silent, acks included, until boot-up is due
        o_net.tx_inhibit = !(s_q.st == ST_BOOT || s_q.st == ST_PREOP);
        o_net.bootup_req = s_q.boot_req;
        o_net.node_id = s_q.act_id;
        o_net.rate_code = s_q.act_rate;
        o_net.bit_period = s_q.bit_period;
        o_net.preop = s_q.st == ST_PREOP;
        o_drive.run_from_network =
            s_q.run_command_source_sel == SRC_OPTION_CARD;
        o_drive.ref_from_network =
            s_q.freq_reference_source_sel == {1'b0, SRC_OPTION_CARD};
        o_drive.run_src = s_q.run_command_source_sel;
        o_drive.freq_src = s_q.freq_reference_source_sel;
        o_drive.display_unit = s_q.speed_display_unit_sel;
        o_drive.pole_count = s_q.motor_pole_count;
        o_drive.multistep_allow = s_q.multistep_reference_allow;
        o_drive.stop_req = s_q.stop_req;
        o_drive.stop_method = s_q.stop_method;
        o_drive.alarm = s_q.alarm;
        o_drive.addr_err_display = s_q.addr_err;
        o_drive.cfg_err = s_q.cfg_err;
        o_run_led = s_q.run_led;
        o_err_led = s_q.err_led;
    end

endmodule

// >>> verification/fieldbus_node_chk_sva.sv
// Purpose: port assertions of the fieldbus node setup block
// Assumes: single clock, async active low reset
// Notes: attached by bind at the foot of this file
`timescale 1ns/1ps
module fieldbus_node_chk
    import fieldbus_node_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_hsel,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic i_hready,
    input wire logic o_hreadyout,
    input wire fieldbus_node_pkg::net_ctl_t o_net,
    input wire fieldbus_node_pkg::drive_ctl_t o_drive,
    input wire logic o_run_led,
    input wire logic o_err_led
);
    logic [1:0] boot_cnt_q;
    // saturates so a runaway pulse train cannot wrap back to legal
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            boot_cnt_q <= 2'h0;
        end else if (o_net.bootup_req && boot_cnt_q != 2'h3) begin
            boot_cnt_q <= boot_cnt_q + 2'h1;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    chk_boot_once: assert property (boot_cnt_q < 2'h2)
        else $error("boot-up sent twice");
    chk_boot_preop: assert property (o_net.bootup_req |=> o_net.preop)
        else $error("no pre-operational after boot-up");
    chk_tx_quiet: assert property (o_net.tx_inhibit |->
        !o_net.bootup_req && !o_net.preop) else $error("sent while muted");
    chk_active_fixed: assert property (o_net.preop && $past(o_net.preop)
        |-> $stable(o_net.rate_code) && $stable(o_net.node_id))
        else $error("active setting moved");
    chk_rate_range: assert property (o_net.preop |->
        o_net.rate_code inside {[4'h1:4'h8]}) else $error("bad rate");
    chk_led_alt: assert property (o_net.tx_inhibit |->
        !(o_run_led && o_err_led)) else $error("both leds on");
    chk_addr_halt: assert property (o_drive.addr_err_display |->
        o_net.tx_inhibit && !o_run_led) else $error("id 0 joined");
    chk_cfg_halt: assert property (o_drive.cfg_err |->
        o_net.tx_inhibit && !o_net.preop) else $error("bad code joined");
    chk_alarm_run: assert property (o_drive.stop_req |->
        o_drive.stop_method != STOP_ALARM_ONLY) else $error("alarm stopped");
    chk_read_wait: assert property (i_hsel && i_htrans[1] && i_hready &&
        !i_hwrite |=> !o_hreadyout ##1 o_hreadyout)
        else $error("read wait state wrong");
endmodule
bind fieldbus_node_bitrate_setup fieldbus_node_chk u_chk (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_hsel(i_hsel),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready),
    .o_hreadyout(o_hreadyout), .o_net(o_net), .o_drive(o_drive),
    .o_run_led(o_run_led), .o_err_led(o_err_led));

// >>> verification/fieldbus_bus_partner.sv
// Purpose: far-side node toggling the bus at one bit rate
// Assumes: bit time given in clock cycles
// Notes: idle bus sits recessive through the termination pull-up
`timescale 1ns/1ps
module fieldbus_bus_partner (
    input wire logic i_clk,
    input wire logic i_en,
    input wire logic [15:0] i_bit_cyc,
    output logic o_rx
);
    logic [15:0] cnt_q;
    always_ff @(posedge i_clk) begin
        if (!i_en) begin
            cnt_q <= 16'h0;
            o_rx <= 1'b1;
        end else if (cnt_q + 16'h1 >= i_bit_cyc) begin
            cnt_q <= 16'h0;
            o_rx <= ~o_rx;
        end else begin
            cnt_q <= cnt_q + 16'h1;
        end
    end
endmodule

// >>> verification/fieldbus_node_bitrate_setup_test.sv
// Purpose: self-checking bench of the fieldbus node setup block
// Assumes: short flicker and detect counts for run time
// Notes: random node ids from a fixed seed
`timescale 1ns/1ps
module fieldbus_node_bitrate_setup_test;
    import fieldbus_node_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic hreadyout, hresp, rx, bus_en = 1'b0, run_led, err_led;
    logic cerr = 1'b0, efault = 1'b0, drv_run = 1'b0, drv_init = 1'b0;
    logic [3:0] nv_code = 4'h6;
    logic [6:0] nv_id = 7'h01;
    logic [15:0] bus_cyc = 16'h0;
    net_ctl_t net;
    drive_ctl_t drv;
    int error_cnt = 0, tests_run = 0, seed;
    always #2 clk = ~clk;
    fieldbus_bus_partner i_bus (.i_clk(clk), .i_en(bus_en),
        .i_bit_cyc(bus_cyc), .o_rx(rx));
    fieldbus_node_bitrate_setup #(.FLICKER_CYCLES(4),
        .DETECT_EDGE_COUNT(8)) i_dut (.i_clk(clk), .i_rst_b(rst_b),
        .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(hreadyout), .o_hrdata(hrdata), .o_hreadyout(hreadyout),
        .o_hresp(hresp), .i_nv_bit_rate_code(nv_code), .i_nv_node_id(nv_id),
        .i_can_rx(rx), .i_comm_error(cerr), .i_ext_fault(efault),
        .i_drive_running(drv_run), .i_drive_init(drv_init), .o_net(net),
        .o_drive(drv), .o_run_led(run_led), .o_err_led(err_led));
    task automatic final_report;
        $display("tests %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wait_on(input int lim, input logic ahb);
        int n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!(ahb ? hreadyout : net.bootup_req) && n < lim);
        if (n >= lim) begin
            chk(32'h0, 32'h1);
            final_report();
        end
    endtask
    task automatic ahb_io(input logic wr, input logic [4:0] a,
                          input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {27'h0, a};
        wait_on(50, 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        wait_on(50, 1'b1);
        rd = hrdata;
    endtask
    task automatic power_up(input logic [3:0] code, input logic [6:0] id);
        rst_b <= 1'b0;
        nv_code <= code;
        nv_id <= id;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
    endtask
    // one-hot {init, ext fault, comm error}, result seen two edges on
    task automatic fire(input logic [2:0] ev);
        {drv_init, efault, cerr} <= ev;
        @(posedge clk);
        {drv_init, efault, cerr} <= 3'h0;
        @(posedge clk);
    endtask
    initial begin
        logic [31:0] rd;
        int c;
        logic [6:0] id;
        seed = 78;
        for (c = 1; c <= 8; c++) begin
            id = 7'($unsigned($random(seed)) % 126 + 1);
            power_up(4'(c), id);
            wait_on(20, 1'b0);
            nv_code <= 4'h0;
            nv_id <= ~id;
            chk(net.rate_code, c);
            chk(net.bit_period, CLK_KHZ / RATE_KBPS[c]);
            @(posedge clk);
            chk(net.node_id, id);
            chk(net.preop, 1'b1);
        end
        $display("fixed rate test done");
        for (c = 5; c <= 8; c++) begin
            power_up(RATE_AUTO, 7'h05);
            bus_cyc <= 16'(CLK_KHZ / RATE_KBPS[c]);
            bus_en <= 1'b1;
            repeat (20) @(posedge clk);
            chk(net.tx_inhibit, 1'b1);
            chk(run_led ^ err_led, 1'b1);
            wait_on(30000, 1'b0);
            chk(net.rate_code, c);
            chk(net.bit_period, CLK_KHZ / RATE_KBPS[c]);
            bus_en <= 1'b0;
        end
        $display("auto rate test done");
        power_up(4'h9, 7'h10);
        repeat (5) @(posedge clk);
        chk(drv.cfg_err, 1'b1);
        chk(err_led, 1'b1);
        chk(net.tx_inhibit, 1'b1);
        power_up(4'h6, 7'h00);
        repeat (5) @(posedge clk);
        chk(drv.addr_err_display, 1'b1);
        chk(net.preop, 1'b0);
        chk(run_led, 1'b0);
        rd[0] = err_led;
        repeat (4) @(posedge clk);
        chk(err_led, !rd[0]);
        $display("bad setting test done");
        power_up(4'h6, 7'h21);
        wait_on(20, 1'b0);
        ahb_io(1'b0, OFS_FAULT_CFG, 32'h0, rd);
        chk(rd, 32'h0000_1101);
        ahb_io(1'b0, OFS_DRIVE_CFG, 32'h0, rd);
        chk(rd, 32'h0400_0101);
        ahb_io(1'b0, 5'h14, 32'h0, rd);
        chk(rd, 32'h0); // unmapped offset reads zero
        ahb_io(1'b1, OFS_NET_CFG, 32'h0000_0208, rd);
        chk(net.rate_code, 4'h6);
        ahb_io(1'b1, OFS_DRIVE_CFG, 32'h3102_0303, rd);
        ahb_io(1'b0, OFS_DRIVE_CFG, 32'h0, rd);
        chk(rd, 32'h0402_0303);
        chk(drv.run_from_network, 1'b1);
        chk(drv.ref_from_network, 1'b1);
        chk(drv.display_unit, 2'h2);
        chk(drv.run_src, 2'h3);
        chk(drv.freq_src, 3'h3);
        chk(drv.pole_count, POLES_RST);
        chk(hresp, 1'b0); // responses always okay
        for (c = 0; c < 4; c++) begin
            ahb_io(1'b1, OFS_FAULT_CFG, 32'(c), rd);
            fire(3'h1);
            chk(drv.stop_req, c != 3);
            if (c != 3) chk(drv.stop_method, c);
            chk(drv.alarm, c == 3);
        end
        chk(drv.multistep_allow, 1'b0);
        ahb_io(1'b1, OFS_FAULT_CFG, 32'h0001_0211, rd);
        fire(3'h2);
        chk(drv.stop_req, 1'b0);
        drv_run <= 1'b1;
        fire(3'h2);
        chk(drv.stop_req, 1'b1);
        chk(drv.stop_method, STOP_FAST);
        fire(3'h4);
        ahb_io(1'b0, OFS_FAULT_CFG, 32'h0, rd);
        chk(rd, 32'h0000_1101);
        ahb_io(1'b0, OFS_NET_CFG, 32'h0, rd);
        chk(rd, {17'h0, NODE_ID_RST, 4'h0, RATE_CODE_RST});
        $display("register and fault test done");
        final_report();
    end
endmodule
